/* hw/cvcc_map.svh */
// Purpose: offsets, field positions, codes and reset values of the value change checker
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: definitions only
`ifndef CVCC_MAP_SVH
`define CVCC_MAP_SVH

`define CVCC_AW 12
`define CVCC_OFS_CTRL 12'h000
`define CVCC_OFS_ADDR 12'h004
`define CVCC_OFS_CMD 12'h008
`define CVCC_OFS_STATUS 12'h00c
`define CVCC_OFS_IRQ_STAT 12'h010
`define CVCC_OFS_IRQ_MASK 12'h014
`define CVCC_OFS_RD_SEL 12'h018
`define CVCC_OFS_RD_VAL 12'h01c
`define CVCC_OFS_AXIS_FLAGS 12'h020
`define CVCC_OFS_ENC_FLAGS 12'h024

`define CVCC_CTRL_SEQ_RDY 0
`define CVCC_CTRL_MP_RDY 1
`define CVCC_CTRL_MODE_LSB 2
`define CVCC_CMD_ENC 0
`define CVCC_CMD_VSHAFT 1
`define CVCC_CMD_PROGV 2
`define CVCC_CMD_IDX_LSB 8
`define CVCC_IDX_W 6
`define CVCC_IRQ_DONE 0
`define CVCC_IRQ_ERR 1

`define CVCC_CLS_NONE 2'h0
`define CVCC_CLS_MINOR 2'h1
`define CVCC_CLS_MAJOR 2'h2
`define CVCC_CLS_SETTING 2'h3

`define CVCC_ERR_NOT_READY 16'h0064
`define CVCC_ERR_STARTED 16'h0065
`define CVCC_ERR_SRV_NRDY 16'h03ec
`define CVCC_ERR_SRV_ERR 16'h03ed
`define CVCC_ERR_VREAL_V 16'h0387
`define CVCC_ERR_OUT_VIRT 16'h0388
`define CVCC_ERR_ENC_REAL 16'h0389
`define CVCC_ERR_R2V 16'h038b
`define CVCC_ERR_V2R 16'h038c
`define CVCC_ERR_RANGE 16'hffff

`define CVCC_CTRL_RST 3'h0
`define CVCC_MASK_RST 2'h0
`define CVCC_NAXIS 32
`define CVCC_NENC 12

`endif

/* hw/cvcc_pkg.sv */
// Purpose: types of the value change checker
// Assumes: macros from cvcc_map.svh
// Notes: no constants here
package cvcc_pkg;

   typedef enum logic [1:0] {
      CVCC_IDLE = 2'b00,
      CVCC_CHECK = 2'b01,
      CVCC_APPLY = 2'b10,
      CVCC_FINISH = 2'b11
   } cvcc_state_t;

   typedef enum logic [1:0] {
      CVCC_REAL = 2'b00,
      CVCC_VIRT = 2'b01,
      CVCC_R2V = 2'b10,
      CVCC_V2R = 2'b11
   } cvcc_mode_t;

   typedef struct packed {
      logic enc;
      logic vshaft;
      logic progv;
      logic [5:0] idx;
      logic [31:0] addr;
   } cvcc_cmd_t;

   typedef struct packed {
      logic [1:0] cls;
      logic [15:0] code;
   } cvcc_err_t;

   typedef struct packed {
      logic seq_rdy;
      logic mp_rdy;
      cvcc_mode_t mode;
   } cvcc_ctrl_t;

endpackage

/* hw/cvcc_sync.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to pclk
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps
module cvcc_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } cvcc_sync_st_t;

   cvcc_sync_st_t r_q;
   cvcc_sync_st_t r_d;

   always_comb begin
      r_d = r_q;
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      for (int i = 0; i < W; i++) begin
         if (r_q.s2[i] == r_q.s3[i]) begin
            r_d.q[i] = r_q.s3[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign q = r_q.q;
endmodule

/* hw/cvcc_value_store.sv */
// Purpose: current value array with one write port and per-entry increment
// Assumes: write wins over increment on the same entry
// Notes: no reset, contents retained across presetn
`timescale 1ns/1ps
module cvcc_value_store #(
   parameter int N = 12,
   parameter int W = 32
) (
   input wire logic pclk,
   input wire logic we,
   input wire logic [5:0] widx,
   input wire logic [W-1:0] wdata,
   input wire logic [N-1:0] inc,
   output logic [N-1:0][W-1:0] vals
);
   typedef struct packed {
      logic [N-1:0][W-1:0] v;
   } cvcc_store_st_t;

   cvcc_store_st_t r_q;
   cvcc_store_st_t r_d;

   always_comb begin
      r_d = r_q;
      for (int i = 0; i < N; i++) begin
         if (we && (widx == 6'(i))) begin
            r_d.v[i] = wdata;
         end else if (inc[i]) begin
            r_d.v[i] = W'(r_q.v[i] + 1'b1);
         end
      end
   end

   always_ff @(posedge pclk) begin
      r_q <= r_d;
   end

   assign vals = r_q.v;
endmodule

/* hw/cvcc_top.sv */
// Purpose: checks and executes current value change commands over APB
// Assumes: one clock pclk, asynchronous active-low presetn, APB3 slave, zero wait
// Notes: axis, virtual shaft and encoder values held in retained stores
`timescale 1ns/1ps
`include "cvcc_map.svh"
module cvcc_top #(
   parameter int NAXIS = `CVCC_NAXIS,
   parameter int NENC = `CVCC_NENC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`CVCC_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [NAXIS-1:0] servo_ready_in,
   input wire logic [NAXIS-1:0] servo_error_in,
   input wire logic [NAXIS-1:0] axis_moving_in,
   input wire logic [NENC-1:0] enc_pulse_in,
   output logic [NAXIS-1:0] axis_start_accept_flags,
   output logic [NENC-1:0] encoder_change_busy_flags,
   output logic change_busy,
   output logic irq
);
   typedef struct packed {
      cvcc_pkg::cvcc_state_t st;
      cvcc_pkg::cvcc_ctrl_t ctrl;
      logic [31:0] addr;
      cvcc_pkg::cvcc_cmd_t cmd;
      cvcc_pkg::cvcc_err_t err;
      logic err_valid;
      logic [5:0] err_shaft;
      logic [NAXIS-1:0] aflag;
      logic [NENC-1:0] eflag;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [1:0] rd_arr;
      logic [5:0] rd_idx;
      logic [NENC-1:0] pulse_prev;
      logic [31:0] rdata;
   } cvcc_st_t;

   cvcc_st_t r_q;
   cvcc_st_t r_d;

   logic [NAXIS-1:0] srv_rdy_s, srv_err_s, moving_s;
   logic [NENC-1:0] pulse_s, enc_inc;
   logic [NAXIS-1:0][31:0] axis_vals, virt_vals;
   logic [NENC-1:0][31:0] enc_vals;
   logic [5:0] sidx, ridx0;
   logic axis_we, virt_we, enc_we, mapped, acc, wr, cmd_go;
   logic [31:0] rmux, rval;
   cvcc_pkg::cvcc_err_t chk;

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   cvcc_sync #(.W(NAXIS)) u_sync_rdy (.pclk(pclk), .presetn(presetn), .d(servo_ready_in),
      .q(srv_rdy_s));
   cvcc_sync #(.W(NAXIS)) u_sync_err (.pclk(pclk), .presetn(presetn), .d(servo_error_in),
      .q(srv_err_s));
   cvcc_sync #(.W(NAXIS)) u_sync_mov (.pclk(pclk), .presetn(presetn), .d(axis_moving_in),
      .q(moving_s));
   cvcc_sync #(.W(NENC)) u_sync_pulse (.pclk(pclk), .presetn(presetn), .d(enc_pulse_in),
      .q(pulse_s));

   ////////////////////////////////////////////////////////////////////////
   // retained value stores
   assign sidx = 6'(r_q.cmd.idx - 6'h01);
   assign axis_we = (r_q.st == cvcc_pkg::CVCC_APPLY) && !r_q.cmd.enc && !r_q.cmd.vshaft;
   assign virt_we = (r_q.st == cvcc_pkg::CVCC_APPLY) && !r_q.cmd.enc && r_q.cmd.vshaft;
   assign enc_we = (r_q.st == cvcc_pkg::CVCC_APPLY) && r_q.cmd.enc;
   // feed counting only while virtual operation runs
   assign enc_inc = (pulse_s & ~r_q.pulse_prev)
                    & {NENC{r_q.ctrl.mode == cvcc_pkg::CVCC_VIRT}};

   cvcc_value_store #(.N(NAXIS), .W(32)) u_axis_store (.pclk(pclk), .we(axis_we),
      .widx(sidx), .wdata(r_q.cmd.addr), .inc('0), .vals(axis_vals));
   cvcc_value_store #(.N(NAXIS), .W(32)) u_virt_store (.pclk(pclk), .we(virt_we),
      .widx(sidx), .wdata(r_q.cmd.addr), .inc('0), .vals(virt_vals));
   cvcc_value_store #(.N(NENC), .W(32)) u_enc_store (.pclk(pclk), .we(enc_we),
      .widx(sidx), .wdata(r_q.cmd.addr), .inc(enc_inc), .vals(enc_vals));

   ////////////////////////////////////////////////////////////////////////
   // command checks in priority order
   always_comb begin
      chk = '{cls: `CVCC_CLS_NONE, code: 16'h0000};
      if (!(r_q.ctrl.seq_rdy && r_q.ctrl.mp_rdy)) begin
         chk = '{cls: `CVCC_CLS_MINOR, code: `CVCC_ERR_NOT_READY};
      end else if ((r_q.cmd.idx == 6'h00)
                   || (r_q.cmd.enc && (r_q.cmd.idx > 6'(NENC)))
                   || (!r_q.cmd.enc && (r_q.cmd.idx > 6'(NAXIS)))) begin
         chk = '{cls: `CVCC_CLS_SETTING, code: `CVCC_ERR_RANGE};
      end else if (r_q.ctrl.mode == cvcc_pkg::CVCC_R2V) begin
         chk = '{cls: `CVCC_CLS_SETTING, code: `CVCC_ERR_R2V};
      end else if (r_q.ctrl.mode == cvcc_pkg::CVCC_V2R) begin
         chk = '{cls: `CVCC_CLS_SETTING, code: `CVCC_ERR_V2R};
      end else if (r_q.cmd.enc) begin
         if (r_q.ctrl.mode == cvcc_pkg::CVCC_REAL) begin
            chk = '{cls: `CVCC_CLS_SETTING,
                    code: r_q.cmd.progv ? `CVCC_ERR_VREAL_V : `CVCC_ERR_ENC_REAL};
         end
      end else if (r_q.cmd.vshaft) begin
         if (r_q.ctrl.mode == cvcc_pkg::CVCC_REAL) begin
            chk = '{cls: `CVCC_CLS_SETTING, code: `CVCC_ERR_VREAL_V};
         end
      end else if (r_q.ctrl.mode == cvcc_pkg::CVCC_VIRT) begin
         chk = '{cls: `CVCC_CLS_SETTING, code: `CVCC_ERR_OUT_VIRT};
      end else if (moving_s[sidx[4:0]]) begin
         chk = '{cls: `CVCC_CLS_MINOR, code: `CVCC_ERR_STARTED};
      end else if (!srv_rdy_s[sidx[4:0]]) begin
         chk = '{cls: `CVCC_CLS_MAJOR, code: `CVCC_ERR_SRV_NRDY};
      end else if (srv_err_s[sidx[4:0]]) begin
         chk = '{cls: `CVCC_CLS_MAJOR, code: `CVCC_ERR_SRV_ERR};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb decode and read mux
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `CVCC_OFS_ENC_FLAGS);
   assign cmd_go = wr && (paddr == `CVCC_OFS_CMD) && (r_q.st == cvcc_pkg::CVCC_IDLE);
   assign pready = 1'b1;
   assign pslverr = acc && (!mapped
                    || (pwrite && (paddr == `CVCC_OFS_CMD) && (r_q.st != cvcc_pkg::CVCC_IDLE)));

   assign ridx0 = 6'(r_q.rd_idx - 6'h01);
   always_comb begin
      rval = 32'h0000_0000;
      if (r_q.rd_idx != 6'h00) begin
         case (r_q.rd_arr)
            2'h0: rval = (r_q.rd_idx <= 6'(NAXIS)) ? axis_vals[ridx0[4:0]] : 32'h0000_0000;
            2'h1: rval = (r_q.rd_idx <= 6'(NAXIS)) ? virt_vals[ridx0[4:0]] : 32'h0000_0000;
            2'h2: rval = (r_q.rd_idx <= 6'(NENC)) ? enc_vals[ridx0[3:0]] : 32'h0000_0000;
            default: rval = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      case (paddr)
         `CVCC_OFS_CTRL: rmux = 32'({r_q.ctrl.mode, r_q.ctrl.mp_rdy, r_q.ctrl.seq_rdy});
         `CVCC_OFS_ADDR: rmux = r_q.addr;
         `CVCC_OFS_STATUS: rmux = {r_q.err.code, 2'h0, r_q.err_shaft, 4'h0, r_q.err.cls,
                                   r_q.err_valid, r_q.st != cvcc_pkg::CVCC_IDLE};
         `CVCC_OFS_IRQ_STAT: rmux = 32'(r_q.irq_stat);
         `CVCC_OFS_IRQ_MASK: rmux = 32'(r_q.irq_mask);
         `CVCC_OFS_RD_SEL: rmux = 32'({r_q.rd_idx, 6'h00, r_q.rd_arr});
         `CVCC_OFS_RD_VAL: rmux = rval;
         `CVCC_OFS_AXIS_FLAGS: rmux = 32'(r_q.aflag);
         `CVCC_OFS_ENC_FLAGS: rmux = 32'(r_q.eflag);
         default: rmux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [1:0] ev;
      ev = 2'h0;
      r_d = r_q;
      r_d.pulse_prev = pulse_s;
      if (psel && !penable) begin
         r_d.rdata = rmux;
      end
      if (wr) begin
         case (paddr)
            `CVCC_OFS_CTRL: begin
               r_d.ctrl = cvcc_pkg::cvcc_ctrl_t'({pwdata[`CVCC_CTRL_SEQ_RDY],
                          pwdata[`CVCC_CTRL_MP_RDY],
                          pwdata[`CVCC_CTRL_MODE_LSB+1:`CVCC_CTRL_MODE_LSB]});
            end
            `CVCC_OFS_ADDR: r_d.addr = pwdata;
            `CVCC_OFS_IRQ_MASK: r_d.irq_mask = pwdata[1:0];
            `CVCC_OFS_RD_SEL: begin
               r_d.rd_arr = pwdata[1:0];
               r_d.rd_idx = pwdata[`CVCC_CMD_IDX_LSB+`CVCC_IDX_W-1:`CVCC_CMD_IDX_LSB];
            end
            default: begin
            end
         endcase
      end
      case (r_q.st)
         cvcc_pkg::CVCC_IDLE: begin
            if (cmd_go) begin
               r_d.cmd.enc = pwdata[`CVCC_CMD_ENC];
               r_d.cmd.vshaft = pwdata[`CVCC_CMD_VSHAFT];
               r_d.cmd.progv = pwdata[`CVCC_CMD_PROGV];
               r_d.cmd.idx = pwdata[`CVCC_CMD_IDX_LSB+`CVCC_IDX_W-1:`CVCC_CMD_IDX_LSB];
               r_d.cmd.addr = r_q.addr;
               r_d.st = cvcc_pkg::CVCC_CHECK;
            end
         end
         cvcc_pkg::CVCC_CHECK: begin
            if (chk.cls != `CVCC_CLS_NONE) begin
               // flags left alone on any failure
               r_d.err = chk;
               r_d.err_valid = 1'b1;
               r_d.err_shaft = r_q.cmd.idx;
               ev[`CVCC_IRQ_ERR] = 1'b1;
               r_d.st = cvcc_pkg::CVCC_IDLE;
            end else begin
               if (r_q.cmd.enc) begin
                  r_d.eflag[sidx[3:0]] = 1'b1;
               end else begin
                  r_d.aflag[sidx[4:0]] = 1'b1;
               end
               r_d.st = cvcc_pkg::CVCC_APPLY;
            end
         end
         cvcc_pkg::CVCC_APPLY: begin
            r_d.st = cvcc_pkg::CVCC_FINISH;
         end
         cvcc_pkg::CVCC_FINISH: begin
            r_d.eflag = '0;
            r_d.aflag = '0;
            r_d.err_valid = 1'b0;
            ev[`CVCC_IRQ_DONE] = 1'b1;
            r_d.st = cvcc_pkg::CVCC_IDLE;
         end
         default: begin
            r_d.st = cvcc_pkg::CVCC_IDLE;
         end
      endcase
      // set wins over write-one-to-clear
      if (wr && (paddr == `CVCC_OFS_IRQ_STAT)) begin
         r_d.irq_stat = r_q.irq_stat & ~pwdata[1:0];
      end
      r_d.irq_stat = r_d.irq_stat | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '0;
         r_q.ctrl <= cvcc_pkg::cvcc_ctrl_t'(`CVCC_CTRL_RST);
         r_q.irq_mask <= `CVCC_MASK_RST;
      end else begin
         r_q <= r_d;
      end
   end

   assign prdata = r_q.rdata;
   assign axis_start_accept_flags = r_q.aflag;
   assign encoder_change_busy_flags = r_q.eflag;
   assign change_busy = r_q.st != cvcc_pkg::CVCC_IDLE;
   assign irq = |(r_q.irq_stat & r_q.irq_mask);

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic in_chk, rdy, in_rng;
   assign in_chk = r_q.st == cvcc_pkg::CVCC_CHECK;
   assign rdy = r_q.ctrl.seq_rdy && r_q.ctrl.mp_rdy;
   assign in_rng = (r_q.cmd.idx != 6'h00)
                   && (r_q.cmd.idx <= (r_q.cmd.enc ? 6'(NENC) : 6'(NAXIS)));
   property p_not_ready;
      @(posedge pclk) disable iff (!presetn)
      (in_chk && !rdy) |=> (r_q.err.code == 16'h0064) && (r_q.st == cvcc_pkg::CVCC_IDLE)
                           && (r_q.aflag == '0) && (r_q.eflag == '0);
   endproperty
   a_not_ready: assert property (p_not_ready) else $error("ready flags off not rejected");
   property p_started;
      @(posedge pclk) disable iff (!presetn)
      (in_chk && rdy && (chk.code == `CVCC_ERR_STARTED)) |-> !r_q.cmd.enc && !r_q.cmd.vshaft
         && moving_s[sidx[4:0]] ##1 r_q.err.code == 16'h0065 && !axis_we;
   endproperty
   a_started: assert property (p_started) else $error("moving axis not rejected");
   property p_servo;
      @(posedge pclk) disable iff (!presetn)
      (in_chk && rdy && !r_q.cmd.enc && !r_q.cmd.vshaft && in_rng
       && r_q.ctrl.mode == cvcc_pkg::CVCC_REAL && !moving_s[sidx[4:0]])
      |=> (r_q.err.code == ($past(srv_rdy_s[sidx[4:0]]) ?
              ($past(srv_err_s[sidx[4:0]]) ? 16'h03ed : r_q.err.code) : 16'h03ec))
          && (r_q.err.cls == 2'h2 || r_q.st == cvcc_pkg::CVCC_APPLY);
   endproperty
   a_servo: assert property (p_servo) else $error("servo check wrong");
   property p_mode_axis;
      @(posedge pclk) disable iff (!presetn)
      (in_chk && rdy && !r_q.cmd.enc && in_rng
       && (r_q.cmd.vshaft ? r_q.ctrl.mode == cvcc_pkg::CVCC_REAL
                          : r_q.ctrl.mode == cvcc_pkg::CVCC_VIRT))
      |=> r_q.err.code == (r_q.cmd.vshaft ? 16'h0387 : 16'h0388) ##1 !virt_we && !axis_we;
   endproperty
   a_mode_axis: assert property (p_mode_axis) else $error("shaft mode check wrong");
   property p_switching;
      @(posedge pclk) disable iff (!presetn)
      (in_chk && rdy && in_rng && r_q.ctrl.mode[1])
      |=> r_q.err.code == (r_q.ctrl.mode == cvcc_pkg::CVCC_R2V ? 16'h038b : 16'h038c);
   endproperty
   a_switching: assert property (p_switching) else $error("switching not rejected");
   property p_enc_real;
      @(posedge pclk) disable iff (!presetn)
      (in_chk && rdy && r_q.cmd.enc && r_q.cmd.idx == 6'h01
       && r_q.ctrl.mode == cvcc_pkg::CVCC_REAL)
      |=> r_q.err.code == (r_q.cmd.progv ? 16'h0387 : 16'h0389) && r_q.err.cls == 2'h3;
   endproperty
   a_enc_real: assert property (p_enc_real) else $error("encoder real mode wrong");

   property p_enc_range;
      @(posedge pclk) disable iff (!presetn)
      (in_chk && rdy && r_q.cmd.enc && (r_q.cmd.idx == 6'h00 || r_q.cmd.idx > 6'(NENC)))
      |=> r_q.err_valid && r_q.err.code == `CVCC_ERR_RANGE;
   endproperty
   a_enc_range: assert property (p_enc_range) else $error("encoder index not checked");

   property p_enc_seq;
      @(posedge pclk) disable iff (!presetn)
      (in_chk && chk.cls == 2'h0 && r_q.cmd.enc)
      |=> r_q.eflag[sidx[3:0]] && change_busy ##1 r_q.eflag[sidx[3:0]]
          ##1 enc_vals[sidx[3:0]] == r_q.cmd.addr ##1 r_q.eflag == '0;
   endproperty
   a_enc_seq: assert property (p_enc_seq) else $error("encoder change sequence wrong");

   property p_axis_seq;
      @(posedge pclk) disable iff (!presetn)
      (in_chk && chk.cls == 2'h0 && !r_q.cmd.enc && !r_q.cmd.vshaft)
      |=> r_q.aflag[sidx[4:0]] ##2 !r_q.aflag[sidx[4:0]]
          && axis_vals[sidx[4:0]] == r_q.cmd.addr;
   endproperty
   a_axis_seq: assert property (p_axis_seq) else $error("axis change sequence wrong");

   property p_no_out_touch;
      @(posedge pclk) disable iff (!presetn)
      (r_q.st == cvcc_pkg::CVCC_APPLY && r_q.cmd.enc) |=> $stable(axis_vals);
   endproperty
   a_no_out_touch: assert property (p_no_out_touch) else $error("output value touched");

   property p_feed;
      @(posedge pclk) disable iff (!presetn)
      (r_q.st == cvcc_pkg::CVCC_FINISH && r_q.cmd.enc && enc_inc[sidx[3:0]])
      |=> enc_vals[sidx[3:0]] == 32'(r_q.cmd.addr + 32'h0000_0001);
   endproperty
   a_feed: assert property (p_feed) else $error("feed not from new value");

   property p_fail_flags;
      @(posedge pclk) disable iff (!presetn)
      (in_chk && chk.cls != 2'h0) |=> r_q.aflag == '0 && r_q.eflag == '0 && r_q.err_valid
         && r_q.err_shaft == $past(r_q.cmd.idx) && r_q.irq_stat[1];
   endproperty
   a_fail_flags: assert property (p_fail_flags) else $error("failure toggled flags");
endmodule

/* dv/cvcc_far_model.sv */
// Purpose: servo amplifier and encoder side seen by the checker
// Assumes: fixed axis conditions, one encoder pulse per kick
// Notes: axis 5 not ready, axis 6 in error, axis 7 moving
`timescale 1ns/1ps
module cvcc_far_model (
   input wire logic kick,
   output logic [31:0] servo_ready_in,
   output logic [31:0] servo_error_in,
   output logic [31:0] axis_moving_in,
   output logic [11:0] enc_pulse_in
);
   assign servo_ready_in = 32'hffffffef;
   assign servo_error_in = 32'h00000020;
   assign axis_moving_in = 32'h00000040;
   assign enc_pulse_in = {11'h000, kick};
endmodule

/* dv/current_value_change_checker_tb_top.sv */
// Purpose: self-checking bench of the value change checker
// Assumes: far side model drives servo and encoder pins
// Notes: table rows first, then busy, irq, pulse, unmapped and reset cases
`timescale 1ns/1ps
`include "cvcc_map.svh"
module current_value_change_checker_tb_top;
   typedef struct packed {logic [3:0] ctrl; logic [15:0] cmd; logic [15:0] code;} cvcc_row_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, kick = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, d, sr, se, sm, aflg;
   logic pready, pslverr, change_busy, irq, e, saw_a, saw_e;
   logic [11:0] eflg, epul;
   int miscompares = 0, check_count = 0, i;
   cvcc_row_t rows [14];
   always #4 pclk = ~pclk;
   cvcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .servo_ready_in(sr), .servo_error_in(se), .axis_moving_in(sm),
      .enc_pulse_in(epul), .axis_start_accept_flags(aflg), .encoder_change_busy_flags(eflg),
      .change_busy(change_busy), .irq(irq));
   cvcc_far_model u_far (.kick(kick), .servo_ready_in(sr), .servo_error_in(se),
      .axis_moving_in(sm), .enc_pulse_in(epul));
   ////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d, wrong %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 8) begin
         @(posedge pclk);
         n++;
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         miscompares++;
         test_done();
      end
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      @(posedge pclk);
      @(negedge pclk);
      while (change_busy !== 1'b0 && n < 20) begin
         saw_a = saw_a | (|aflg);
         saw_e = saw_e | (|eflg);
         @(negedge pclk);
         n++;
      end
      if (n >= 20) begin
         miscompares++;
         test_done();
      end
   endtask
   task automatic run(input cvcc_row_t r, input logic [31:0] a);
      logic ok;
      logic [1:0] c;
      ok = (r.code === 16'h0000);
      c = (r.code < 16'h0066) ? 2'h1
          : (r.code == 16'h03ec || r.code == 16'h03ed) ? 2'h2 : 2'h3;
      apb(1'b1, `CVCC_OFS_CTRL, {28'h0, r.ctrl});
      apb(1'b1, `CVCC_OFS_ADDR, a);
      apb(1'b1, `CVCC_OFS_RD_SEL, {18'h0, r.cmd[13:8], 6'h0, r.cmd[0], r.cmd[1]});
      @(negedge pclk);
      saw_a = 1'b0;
      saw_e = 1'b0;
      apb(1'b1, `CVCC_OFS_CMD, {16'h0, r.cmd});
      wait_idle();
      chk(saw_a, ok & ~r.cmd[0]);
      chk(saw_e, ok & r.cmd[0]);
      chk(irq, 1'b1);
      apb(1'b0, `CVCC_OFS_STATUS, 32'h0);
      chk({d[1], ok ? 16'h0 : d[31:16]}, {~ok, r.code});
      chk(ok ? 32'h0 : {d[13:8], d[3:2]}, ok ? 32'h0 : {r.cmd[13:8], c});
      apb(1'b0, `CVCC_OFS_RD_VAL, 32'h0);
      chk(d === a, ok);
      apb(1'b0, `CVCC_OFS_IRQ_STAT, 32'h0);
      chk(d[1:0], {~ok, ok});
      apb(1'b1, `CVCC_OFS_IRQ_STAT, 32'h3);
      @(negedge pclk);
      chk(irq, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      rows = '{'{4'h2, 16'h0200, 16'h0064},
         '{4'h3, 16'h0200, 16'h0000},
         '{4'hb, 16'h0200, 16'h038b},
         '{4'hf, 16'h0200, 16'h038c},
         '{4'h3, 16'h0306, 16'h0387},
         '{4'h7, 16'h0200, 16'h0388},
         '{4'h3, 16'h0105, 16'h0387},
         '{4'h3, 16'h0101, 16'h0389},
         '{4'h7, 16'h0c05, 16'h0000},
         '{4'h7, 16'h0d05, 16'hffff},
         '{4'h7, 16'h0306, 16'h0000},
         '{4'h3, 16'h0500, 16'h03ec},
         '{4'h3, 16'h0600, 16'h03ed},
         '{4'h3, 16'h0700, 16'h0065}};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CVCC_OFS_STATUS, 32'h0);
      chk(d, 32'h0);
      apb(1'b1, `CVCC_OFS_IRQ_MASK, 32'h3);
      for (i = 0; i < 14; i++) begin
         run(rows[i], 32'h100 + i);
         $display("test row %0d done", i);
      end
      apb(1'b1, `CVCC_OFS_IRQ_MASK, 32'h0);
      apb(1'b1, `CVCC_OFS_CTRL, 32'h7);
      apb(1'b1, `CVCC_OFS_ADDR, 32'h500);
      apb(1'b1, `CVCC_OFS_CMD, 32'h0105);
      apb(1'b1, `CVCC_OFS_CMD, 32'h0105);
      chk(e, 1'b1);
      wait_idle();
      chk(irq, 1'b0);
      apb(1'b1, `CVCC_OFS_IRQ_MASK, 32'h1);
      @(negedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, `CVCC_OFS_IRQ_STAT, 32'h3);
      kick <= 1'b1;
      repeat (8) @(posedge pclk);
      kick <= 1'b0;
      repeat (12) @(posedge pclk);
      apb(1'b1, `CVCC_OFS_RD_SEL, 32'h0102);
      apb(1'b0, `CVCC_OFS_RD_VAL, 32'h0);
      chk(d, 32'h501);
      apb(1'b0, 12'h040, 32'h0);
      chk(e, 1'b1);
      chk(d, 32'h0);
      $display("test busy, irq, pulse and unmapped done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, `CVCC_OFS_RD_SEL, 32'h0200);
      apb(1'b0, `CVCC_OFS_RD_VAL, 32'h0);
      chk(d, 32'h101);
      apb(1'b0, `CVCC_OFS_CTRL, 32'h0);
      chk(d, 32'h0);
      $display("test reset done");
      test_done();
   end
endmodule
